// ### crs_pkg.sv
// Purpose: Constants shared by the CPU register set
// Assumes: Single 10 MHz core clock
// Notes: Status word layout follows the core's own field placement
package crs_pkg;
  localparam int unsigned NUM_GPR = 16;
  localparam int unsigned XLEN = 32;
  localparam int unsigned ACC_W = 72;
  localparam int unsigned IDX_W = 4;
  localparam logic [3:0] SP_IDX = 4'h0;
  // Status word bit positions
  localparam int unsigned PSW_C = 0;
  localparam int unsigned PSW_Z = 1;
  localparam int unsigned PSW_S = 2;
  localparam int unsigned PSW_O = 3;
  localparam int unsigned PSW_I = 16;
  localparam int unsigned PSW_U = 17;
  localparam int unsigned PSW_PM = 20;
  localparam int unsigned PSW_IPL_LO = 24;
  localparam int unsigned IPL_W = 4;
  localparam logic [31:0] PSW_RESET = 32'h0000_0000;
  localparam logic [31:0] PSW_WMASK = 32'h0F13_000F;
  localparam logic [31:0] FLOAT_STATUS_WORD_RESET = 32'h0000_0100;
  localparam int unsigned FLOAT_STATUS_WORD_OVF = 2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [71:0] ACC_ZERO = 72'h00_0000_0000_0000_0000;
  localparam logic [4:0] VEC_SHIFT = 5'h02;
  // Control register select codes
  typedef enum logic [2:0] {
    CRS_CR_PSW, CRS_CR_INTERRUPT_TABLE_BASE, CRS_CR_EXCEPTION_TABLE_BASE, CRS_CR_BPC, CRS_CR_SAVED_STATUS_FAST, CRS_CR_FAST_VECTOR_TARGET,
    CRS_CR_FLOAT_STATUS_WORD, CRS_CR_NONE
  } crs_creg_t;
endpackage : crs_pkg

// ### crs_cpu_register_set.sv
// Purpose: Architectural register set of the core: general, control, accumulators
// Assumes: Pipeline drives one write per port per cycle, same clock domain
// Notes: Exception and fast interrupt events override software writes to status
`timescale 1ns/100ps

module crs_cpu_register_set (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [3:0] rd_a_idx_i,
  input wire logic [3:0] rd_b_idx_i,
  input wire logic gpr_we_i,
  input wire logic [3:0] gpr_widx_i,
  input wire logic [31:0] gpr_wdata_i,
  input wire logic creg_we_i,
  input wire crs_pkg::crs_creg_t creg_sel_i,
  input wire logic [31:0] creg_wdata_i,
  input wire logic sp_alt_we_i,
  input wire logic [31:0] sp_alt_wdata_i,
  input wire logic [31:0] pc_i,
  input wire logic exc_accept_i,
  input wire logic [7:0] exc_vec_num_i,
  input wire logic irq_req_i,
  input wire logic [3:0] irq_prio_i,
  input wire logic [7:0] irq_vec_num_i,
  input wire logic fast_accept_i,
  input wire logic wait_accept_i,
  input wire logic to_user_i,
  input wire logic fpu_valid_i,
  input wire logic [31:0] fpu_flags_i,
  input wire logic acc_we_i,
  input wire logic acc_sel_i,
  input wire logic [71:0] acc_wdata_i,
  output logic [31:0] rd_a_data_o,
  output logic [31:0] rd_b_data_o,
  output logic [31:0] psw_o,
  output logic [31:0] float_status_word_o,
  output logic [71:0] accumulator_zero_o,
  output logic [71:0] accumulator_one_o,
  output logic [31:0] bpc_o,
  output logic [31:0] saved_status_fast_o,
  output logic irq_accept_o,
  output logic [31:0] int_vec_addr_o,
  output logic [31:0] exc_vec_addr_o,
  output logic [31:0] fast_target_o
);
  logic [31:0] gpr_q [crs_pkg::NUM_GPR];
  logic [31:0] ksp_q, tsp_q, psw_q, interrupt_table_base_q, exception_table_base_q, bpc_q, saved_status_fast_q, fast_vector_target_q, float_status_word_q;
  logic [31:0] psw_d, float_status_word_d;
  logic [71:0] accumulator_zero_q, accumulator_one_q;
  logic [31:0] rd_a_q, rd_b_q, int_vec_q, exc_vec_q, fast_tgt_q;
  logic irq_acc_q;

  wire use_task_sp = psw_q[crs_pkg::PSW_U];
  wire [31:0] sp_cur = use_task_sp ? tsp_q : ksp_q;
  wire [3:0] priority_mask_level = psw_q[crs_pkg::PSW_IPL_LO +: crs_pkg::IPL_W];
  wire irq_ok = irq_req_i && psw_q[crs_pkg::PSW_I] && (irq_prio_i > priority_mask_level);
  wire sp_wr = gpr_we_i && (gpr_widx_i == crs_pkg::SP_IDX);
  wire wr_psw = creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_PSW);
  wire [31:0] rd_a_w = (rd_a_idx_i == crs_pkg::SP_IDX) ? sp_cur : gpr_q[rd_a_idx_i];
  wire [31:0] rd_b_w = (rd_b_idx_i == crs_pkg::SP_IDX) ? sp_cur : gpr_q[rd_b_idx_i];
  wire [31:0] int_vec_w = interrupt_table_base_q + (32'(irq_vec_num_i) << crs_pkg::VEC_SHIFT);
  wire [31:0] exc_vec_w = exception_table_base_q + (32'(exc_vec_num_i) << crs_pkg::VEC_SHIFT);

  // Exception and fast interrupt entry take priority over a software write
  always_comb
  begin
    psw_d = psw_q;
    if (wr_psw)
    begin
      psw_d = creg_wdata_i & crs_pkg::PSW_WMASK;
    end
    if (wait_accept_i)
    begin
      psw_d[crs_pkg::PSW_I] = 1'b1;
    end
    if (to_user_i)
    begin
      psw_d[crs_pkg::PSW_U] = 1'b1;
      psw_d[crs_pkg::PSW_PM] = 1'b1;
    end
    if (exc_accept_i || fast_accept_i || irq_ok)
    begin
      psw_d[crs_pkg::PSW_U] = 1'b0;
      psw_d[crs_pkg::PSW_PM] = 1'b0;
      psw_d[crs_pkg::PSW_I] = 1'b0;
    end
  end

  // Flags are sticky so a pending software clear never drops a new result
  always_comb
  begin
    float_status_word_d = float_status_word_q;
    if (creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_FLOAT_STATUS_WORD))
    begin
      float_status_word_d = creg_wdata_i;
    end
    if (fpu_valid_i)
    begin
      float_status_word_d = float_status_word_d | fpu_flags_i;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < crs_pkg::NUM_GPR; gi++)
    begin : g_gpr
      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
          gpr_q[gi] <= crs_pkg::WORD_ZERO;
        else if (gpr_we_i && (gpr_widx_i == 4'(gi)))
          gpr_q[gi] <= gpr_wdata_i;
      end
    end
  endgenerate
  // Slot zero is never stored: the stack pointers stand in for it
  assign gpr_q[0] = crs_pkg::WORD_ZERO;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ksp_q <= crs_pkg::WORD_ZERO;
      tsp_q <= crs_pkg::WORD_ZERO;
    end
    else
    begin
      if (sp_wr && !use_task_sp)
        ksp_q <= gpr_wdata_i;
      else if (sp_alt_we_i && use_task_sp)
        ksp_q <= sp_alt_wdata_i;
      if (sp_wr && use_task_sp)
        tsp_q <= gpr_wdata_i;
      else if (sp_alt_we_i && !use_task_sp)
        tsp_q <= sp_alt_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      psw_q <= crs_pkg::PSW_RESET;
      float_status_word_q <= crs_pkg::FLOAT_STATUS_WORD_RESET;
      interrupt_table_base_q <= crs_pkg::WORD_ZERO;
      exception_table_base_q <= crs_pkg::WORD_ZERO;
      fast_vector_target_q <= crs_pkg::WORD_ZERO;
    end
    else
    begin
      psw_q <= psw_d;
      float_status_word_q <= float_status_word_d;
      if (creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_INTERRUPT_TABLE_BASE))
        interrupt_table_base_q <= creg_wdata_i;
      if (creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_EXCEPTION_TABLE_BASE))
        exception_table_base_q <= creg_wdata_i;
      if (creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_FAST_VECTOR_TARGET))
        fast_vector_target_q <= creg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bpc_q <= crs_pkg::WORD_ZERO;
      saved_status_fast_q <= crs_pkg::WORD_ZERO;
    end
    else if (fast_accept_i)
    begin
      bpc_q <= pc_i;
      saved_status_fast_q <= psw_q;
    end
    else
    begin
      if (creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_BPC))
        bpc_q <= creg_wdata_i;
      if (creg_we_i && (creg_sel_i == crs_pkg::CRS_CR_SAVED_STATUS_FAST))
        saved_status_fast_q <= creg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      accumulator_zero_q <= crs_pkg::ACC_ZERO;
      accumulator_one_q <= crs_pkg::ACC_ZERO;
    end
    else if (acc_we_i)
    begin
      if (acc_sel_i)
        accumulator_one_q <= acc_wdata_i;
      else
        accumulator_zero_q <= acc_wdata_i;
    end
  end

  // Read data and vectors are registered, costing one cycle of latency
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_a_q <= crs_pkg::WORD_ZERO;
      rd_b_q <= crs_pkg::WORD_ZERO;
      int_vec_q <= crs_pkg::WORD_ZERO;
      exc_vec_q <= crs_pkg::WORD_ZERO;
      fast_tgt_q <= crs_pkg::WORD_ZERO;
      irq_acc_q <= 1'b0;
    end
    else
    begin
      rd_a_q <= rd_a_w;
      rd_b_q <= rd_b_w;
      int_vec_q <= int_vec_w;
      exc_vec_q <= exc_vec_w;
      fast_tgt_q <= fast_vector_target_q;
      irq_acc_q <= irq_ok;
    end
  end

  assign rd_a_data_o = rd_a_q;
  assign rd_b_data_o = rd_b_q;
  assign psw_o = psw_q;
  assign float_status_word_o = float_status_word_q;
  assign accumulator_zero_o = accumulator_zero_q;
  assign accumulator_one_o = accumulator_one_q;
  assign bpc_o = bpc_q;
  assign saved_status_fast_o = saved_status_fast_q;
  assign irq_accept_o = irq_acc_q;
  assign int_vec_addr_o = int_vec_q;
  assign exc_vec_addr_o = exc_vec_q;
  assign fast_target_o = fast_tgt_q;
endmodule // crs_cpu_register_set

// ### crs_cpu_register_set_assertions.sv
// Purpose: Port checks for the CPU register set
// Assumes: One clock, asynchronous active-low reset
// Notes: Status bits I16 U17 PM20, mask level 27:24
`timescale 1ns/100ps
module crs_cpu_register_set_assertions (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [31:0] pc_i,
  input wire logic exc_accept_i,
  input wire logic irq_req_i,
  input wire logic [3:0] irq_prio_i,
  input wire logic fast_accept_i,
  input wire logic wait_accept_i,
  input wire logic to_user_i,
  input wire logic fpu_valid_i,
  input wire logic [31:0] fpu_flags_i,
  input wire logic [31:0] psw_o,
  input wire logic [31:0] float_status_word_o,
  input wire logic [31:0] bpc_o,
  input wire logic [31:0] saved_status_fast_o,
  input wire logic irq_accept_o
);
  wire take = irq_req_i && psw_o[crs_pkg::PSW_I]
    && (irq_prio_i > psw_o[crs_pkg::PSW_IPL_LO +: crs_pkg::IPL_W]);
  // Accept events override set events, so set checks need a calm cycle
  wire calm = !exc_accept_i && !fast_accept_i && !irq_req_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_irq_take: assert property (take |=> irq_accept_o) else $error("no accept");
  a_irq_refuse: assert property (!take |=> !irq_accept_o) else $error("bad accept");
  a_accept_clears: assert property (take |=> !psw_o[crs_pkg::PSW_I])
    else $error("enable kept");
  a_exc_clears: assert property (exc_accept_i |=> !psw_o[crs_pkg::PSW_PM]
    && !psw_o[crs_pkg::PSW_U] && !psw_o[crs_pkg::PSW_I]) else $error("status not cleared");
  a_wait_enables: assert property (wait_accept_i && calm |=> psw_o[crs_pkg::PSW_I])
    else $error("no enable");
  a_user_stack: assert property (to_user_i && calm |=> psw_o[crs_pkg::PSW_U]
    && psw_o[crs_pkg::PSW_PM]) else $error("no user mode");
  a_fast_save: assert property (fast_accept_i |=>
    bpc_o == $past(pc_i) && saved_status_fast_o == $past(psw_o)) else $error("fast save lost");
  a_fpu_overflow: assert property (fpu_valid_i && fpu_flags_i[crs_pkg::FLOAT_STATUS_WORD_OVF] |=>
    float_status_word_o[crs_pkg::FLOAT_STATUS_WORD_OVF]) else $error("overflow lost");
  cover property (irq_accept_o);
  cover property (exc_accept_i);
  cover property (fast_accept_i);
endmodule // crs_cpu_register_set_assertions
bind crs_cpu_register_set crs_cpu_register_set_assertions u_chk (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .pc_i(pc_i),
  .exc_accept_i(exc_accept_i),
  .irq_req_i(irq_req_i),
  .irq_prio_i(irq_prio_i),
  .fast_accept_i(fast_accept_i),
  .wait_accept_i(wait_accept_i),
  .to_user_i(to_user_i),
  .fpu_valid_i(fpu_valid_i),
  .fpu_flags_i(fpu_flags_i),
  .psw_o(psw_o),
  .float_status_word_o(float_status_word_o),
  .bpc_o(bpc_o),
  .saved_status_fast_o(saved_status_fast_o),
  .irq_accept_o(irq_accept_o)
);

// ### crs_cpu_register_set_tb_top.sv
// Purpose: Bench for the CPU register set
// Assumes: 10 MHz clock, reset low for 4 cycles
// Notes: Same-edge stack write uses the old stack select
`timescale 1ns/100ps
module crs_cpu_register_set_tb_top;
  logic clk_sys_i = '0, rstn_i = '0, gpr_we_i = '0, creg_we_i = '0, sp_alt_we_i = '0;
  logic exc_accept_i = '0, irq_req_i = '0, fast_accept_i = '0, wait_accept_i = '0;
  logic to_user_i = '0, fpu_valid_i = '0, acc_we_i = '0, acc_sel_i = '0, irq_accept_o;
  logic [3:0] rd_a_idx_i = '0, rd_b_idx_i = '0, gpr_widx_i = '0, irq_prio_i = '0;
  logic [7:0] exc_vec_num_i = '0, irq_vec_num_i = '0;
  logic [31:0] gpr_wdata_i = '0, creg_wdata_i = '0, sp_alt_wdata_i = '0, pc_i = '0;
  logic [31:0] fpu_flags_i = '0, rd_a_data_o, rd_b_data_o, psw_o, float_status_word_o, bpc_o, saved_status_fast_o;
  logic [31:0] int_vec_addr_o, exc_vec_addr_o, fast_target_o;
  logic [71:0] acc_wdata_i = '0, accumulator_zero_o, accumulator_one_o;
  crs_pkg::crs_creg_t creg_sel_i = crs_pkg::crs_creg_t'(3'h7);
  int bad_count = 0, compares = 0;
  // Mask level, request level, expected accept
  logic [11:0] rows [6] = '{12'h000, 12'h011, 12'h770, 12'h781, 12'hEF1, 12'hFF0};
  initial forever #50 clk_sys_i = ~clk_sys_i;
  crs_cpu_register_set u_dut (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .rd_a_idx_i(rd_a_idx_i),
    .rd_b_idx_i(rd_b_idx_i),
    .gpr_we_i(gpr_we_i),
    .gpr_widx_i(gpr_widx_i),
    .gpr_wdata_i(gpr_wdata_i),
    .creg_we_i(creg_we_i),
    .creg_sel_i(creg_sel_i),
    .creg_wdata_i(creg_wdata_i),
    .sp_alt_we_i(sp_alt_we_i),
    .sp_alt_wdata_i(sp_alt_wdata_i),
    .pc_i(pc_i),
    .exc_accept_i(exc_accept_i),
    .exc_vec_num_i(exc_vec_num_i),
    .irq_req_i(irq_req_i),
    .irq_prio_i(irq_prio_i),
    .irq_vec_num_i(irq_vec_num_i),
    .fast_accept_i(fast_accept_i),
    .wait_accept_i(wait_accept_i),
    .to_user_i(to_user_i),
    .fpu_valid_i(fpu_valid_i),
    .fpu_flags_i(fpu_flags_i),
    .acc_we_i(acc_we_i),
    .acc_sel_i(acc_sel_i),
    .acc_wdata_i(acc_wdata_i),
    .rd_a_data_o(rd_a_data_o),
    .rd_b_data_o(rd_b_data_o),
    .psw_o(psw_o),
    .float_status_word_o(float_status_word_o),
    .accumulator_zero_o(accumulator_zero_o),
    .accumulator_one_o(accumulator_one_o),
    .bpc_o(bpc_o),
    .saved_status_fast_o(saved_status_fast_o),
    .irq_accept_o(irq_accept_o),
    .int_vec_addr_o(int_vec_addr_o),
    .exc_vec_addr_o(exc_vec_addr_o),
    .fast_target_o(fast_target_o)
  );
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Drops every strobe at the taking edge, then waits for settled outputs
  task automatic clr();
    @(posedge clk_sys_i);
    {gpr_we_i, creg_we_i, exc_accept_i, irq_req_i, fast_accept_i} <= '0;
    {wait_accept_i, to_user_i, fpu_valid_i, acc_we_i, sp_alt_we_i} <= '0;
    @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [31:0] d);
    @(posedge clk_sys_i);
    creg_sel_i <= crs_pkg::crs_creg_t'(sel);
    {creg_we_i, creg_wdata_i} <= {1'h1, d};
    clr();
  endtask
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100us;
    bad_count++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    chk(psw_o, '0);
    chk(float_status_word_o, 32'h100);
    rstn_i <= 1'h1;
    $display("reset done");
    wr(3'h1, 32'h1000);
    wr(3'h5, 32'h3000);
    foreach (rows[i])
    begin
      wr(3'h0, {4'h0, rows[i][11:8], 24'h10000});
      @(posedge clk_sys_i);
      {irq_req_i, irq_prio_i, irq_vec_num_i} <= {1'h1, rows[i][7:4], 8'(i)};
      clr();
      chk(irq_accept_o, rows[i][0]);
      chk(int_vec_addr_o, 32'h1000 + 4 * i);
    end
    $display("table done");
    @(posedge clk_sys_i);
    {fast_accept_i, pc_i, fpu_valid_i, fpu_flags_i} <= {1'h1, 32'h1234, 1'h1, 32'h4};
    {acc_we_i, acc_sel_i, acc_wdata_i} <= {2'h3, 72'hAB};
    clr();
    chk(bpc_o, 32'h1234);
    chk(saved_status_fast_o, 32'h0F010000);
    chk(fast_target_o, 32'h3000);
    chk(float_status_word_o, 32'h104);
    chk(accumulator_one_o, 72'hAB);
    $display("fast done");
    wr(3'h2, 32'h2000);
    wr(3'h0, 32'h130000);
    @(posedge clk_sys_i);
    {exc_accept_i, gpr_we_i, gpr_wdata_i, exc_vec_num_i} <= {2'h3, 32'hAAAA, 8'h3};
    clr();
    chk(psw_o, '0);
    chk(exc_vec_addr_o, 32'h200C);
    @(posedge clk_sys_i);
    {gpr_we_i, gpr_wdata_i} <= {1'h1, 32'h5555};
    clr();
    @(posedge clk_sys_i);
    {to_user_i, wait_accept_i} <= 2'h3;
    clr();
    chk(psw_o, 32'h130000);
    chk(rd_a_data_o, 32'h5555);
    @(negedge clk_sys_i);
    chk(rd_a_data_o, 32'hAAAA);
    $display("stack done");
    // Enable low with a request above the mask: the enable alone must refuse it
    wr(3'h0, 32'h0);
    @(posedge clk_sys_i);
    {sp_alt_we_i, sp_alt_wdata_i, irq_req_i, irq_prio_i} <= {1'h1, 32'h7777, 1'h1, 4'hF};
    {gpr_we_i, gpr_widx_i, gpr_wdata_i} <= {1'h1, 4'h5, 32'h6666};
    {acc_we_i, acc_sel_i, acc_wdata_i} <= {2'h2, 72'hCD};
    clr();
    chk(irq_accept_o, 1'h0);
    chk(accumulator_zero_o, 72'hCD);
    @(posedge clk_sys_i);
    {rd_b_idx_i, to_user_i} <= {4'h5, 1'h1};
    clr();
    chk(rd_b_data_o, 32'h6666);
    @(negedge clk_sys_i);
    chk(rd_a_data_o, 32'h7777);
    $display("alternate done");
    @(posedge clk_sys_i);
    rstn_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    chk(psw_o, '0);
    chk(float_status_word_o, 32'h100);
    chk(accumulator_zero_o, '0);
    chk(bpc_o, '0);
    rstn_i <= 1'h1;
    repeat (2) @(negedge clk_sys_i);
    chk(rd_b_data_o, '0);
    chk(rd_a_data_o, '0);
    $display("mid reset done");
    conclude();
  end
endmodule // crs_cpu_register_set_tb_top
